// ===== cfc_cmd.sv
// uart framed command interpreter with settings, eeprom and image store
// assumes rxd and cts_n synchronous to hclk, one ahb-lite master
//
// Contract
// - output-write sets both digital outputs; hop override takes precedence
// - pwm period fixed; code 0x00 always low, 0xff always high
// - ratio code sets high share; 0x80 gives equal halves
// - pwm command takes one ratio byte, answers header and opcode
// - power command takes a level byte, answers header and accepted level
// - power codes 0..3 accepted, 0 is highest; others ignored
// - eeprom read answers header, start, length, then the data bytes
// - eeprom write stores bytes, answers start, length, last byte after cycle
// - vendor code written once, never read back, never changed
// - vendor query ffff stores nothing, answers 0000 set or ffff unset
// - with code set, only peers with equal code are accepted
// - flash write takes start, length, data; answers five bytes with result
// - start plus length beyond image area gives bounds result
// - flash result codes ok, timeout, bounds, image already valid
// - decrypt answers three bytes with ok, integrity or done status
// - decrypted image loaded at reboot, never read back
// - upgrade changes only the firmware version byte of the eeprom
// - link defaults to 115200 8n1 with hardware flow control
// - erase command clears the reserve image and echoes header and opcode
// - header then 0xff reboots into the activated image
`timescale 1ns/1ps
module cfc_cmd
  import cfc_pkg::*;
#(
   parameter int         PWM_CYC  = cfc_pkg::PWM_PERIOD_CYC,
   parameter int         TMO_CYC  = cfc_pkg::RX_TIMEOUT_CYC,
   parameter logic [7:0] NEW_FW_VER = 8'h01
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        clk_en,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        uart_rxd,
   output logic             uart_txd,
   input  wire logic        uart_cts_n,
   output logic             uart_rts_n,
   input  wire logic        hop_override_en,
   input  wire logic [1:0]  hop_override_val,
   output logic      [1:0]  gpo_out,
   output logic             pwm_out,
   output logic      [1:0]  max_power,
   input  wire logic [15:0] peer_vid,
   output logic             peer_accept,
   output logic             reboot
);
   import cfc_pkg::*;

   function automatic logic known_op(input logic [7:0] b);
      known_op = b inside {OP_GPO, OP_PWM, OP_PWR, OP_EERD, OP_EEWR, OP_FLWR,
                           OP_DECR, OP_ERASE, OP_VID, OP_REBOOT};
   endfunction
   function automatic logic [2:0] arg_cnt(input logic [7:0] b);
      case (b)
         OP_GPO, OP_PWM, OP_PWR: arg_cnt = 3'd1;
         OP_EERD, OP_EEWR:       arg_cnt = 3'd2;
         OP_VID:                 arg_cnt = 3'd3;
         OP_FLWR:                arg_cnt = 3'd4;
         default:                arg_cnt = 3'd0;
      endcase
   endfunction

   cfc_ctrl_t   ctrl;
   cfc_stat_t   stat;
   cfc_state_t  state;
   logic [7:0]  ee [0:EE_DEPTH-1];
   logic [7:0]  img [0:IMG_SIZE-1];
   logic        rx_busy, rx_valid, tx_busy, tx_go, tx_ready, hold, ee_we;
   logic [15:0] rx_cnt, tx_cnt, addr, flen, vid, pc;
   logic [3:0]  rx_bit, tx_bit;
   logic [7:0]  rx_sh, rx_byte, op, res, last, ratio, dcnt, scnt, saddr, ee_wa, ee_wd, tx_data;
   logic [9:0]  tx_sh;
   logic [2:0]  acnt, ridx, rlen;
   logic [7:0]  arg [0:3];
   logic [7:0]  resp [0:4];
   logic [31:0] tmr;
   logic [1:0]  gpo, power;
   logic        vid_set, img_written, img_decr, wr_pend;
   logic [7:0]  wr_addr;
   logic [15:0] next_len;
   logic [23:0] hi_cyc;

   // ahb-lite slave, zero wait states
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign stat = '{busy: state != S_HDR, img_decr: img_decr, img_written: img_written,
                   vid_set: vid_set, max_power: power, gpo: gpo};
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl    <= '{flow_en: FLOW_RST, baud_div: BAUD_DIV};
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
         hrdata  <= 32'h0;
      end else if (clk_en) begin
         if (wr_pend && wr_addr == REG_CTRL) begin
            ctrl.flow_en <= hwdata[0];
         end
         if (wr_pend && wr_addr == REG_BAUD && hwdata[15:0] != 16'h0) begin
            ctrl.baud_div <= hwdata[15:0];
         end
         wr_pend <= 1'b0;
         if (hsel && hready && htrans[1]) begin
            wr_pend <= hwrite;
            wr_addr <= (haddr[31:8] == 24'h0) ? haddr[7:0] : 8'hff;
            if (!hwrite) begin
               case ((haddr[31:8] == 24'h0) ? haddr[7:0] : 8'hff)
                  REG_CTRL: hrdata <= {31'h0, ctrl.flow_en};
                  REG_BAUD: hrdata <= {16'h0, ctrl.baud_div};
                  REG_STAT: hrdata <= {24'h0, stat};
                  REG_PWM:  hrdata <= {24'h0, ratio};
                  default:  hrdata <= 32'h0;
               endcase
            end
         end
      end
   end

   // uart receiver, 8n1
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_busy  <= 1'b0;
         rx_valid <= 1'b0;
         rx_cnt   <= 16'h0;
         rx_bit   <= 4'h0;
         rx_sh    <= 8'h00;
         rx_byte  <= 8'h00;
      end else if (clk_en) begin
         rx_valid <= 1'b0;
         if (!rx_busy) begin
            if (!uart_rxd) begin
               rx_busy <= 1'b1;
               rx_cnt  <= ctrl.baud_div >> 1;
               rx_bit  <= 4'h0;
            end
         end else if (rx_cnt != 16'h0) begin
            rx_cnt <= rx_cnt - 16'h1;
         end else begin
            rx_cnt <= ctrl.baud_div - 16'h1;
            rx_bit <= rx_bit + 4'h1;
            if (rx_bit == 4'h0 && uart_rxd) begin
               rx_busy <= 1'b0;
            end else if (rx_bit == 4'h9) begin
               rx_busy  <= 1'b0;
               rx_valid <= uart_rxd;
               rx_byte  <= rx_sh;
            end else begin
               rx_sh <= {uart_rxd, rx_sh[7:1]};
            end
         end
      end
   end

   // uart transmitter, held off by cts_n under flow control
   assign tx_ready = !tx_busy && !(ctrl.flow_en && uart_cts_n);
   assign tx_go    = (state == S_RESP || state == S_STREAM) && tx_ready;
   assign tx_data  = (state == S_STREAM) ? ee[saddr] : resp[ridx];
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tx_busy  <= 1'b0;
         tx_cnt   <= 16'h0;
         tx_bit   <= 4'h0;
         tx_sh    <= 10'h3ff;
         uart_txd <= 1'b1;
      end else if (clk_en) begin
         if (!tx_busy) begin
            uart_txd <= 1'b1;
            if (tx_go) begin
               tx_busy <= 1'b1;
               tx_sh   <= {1'b1, tx_data, 1'b0};
               tx_cnt  <= 16'h0;
               tx_bit  <= 4'h0;
            end
         end else if (tx_cnt != 16'h0) begin
            tx_cnt <= tx_cnt - 16'h1;
         end else begin
            uart_txd <= tx_sh[0];
            tx_sh    <= {1'b1, tx_sh[9:1]};
            tx_cnt   <= ctrl.baud_div - 16'h1;
            tx_bit   <= tx_bit + 4'h1;
            if (tx_bit == 4'ha) begin
               tx_busy <= 1'b0;
            end
         end
      end
   end

   // stop the host while no byte can be taken
   assign hold = state inside {S_WAIT, S_EXEC, S_RESP, S_STREAM} || tx_busy;
   assign uart_rts_n = ctrl.flow_en && hold;

   // eeprom and image stores
   assign ee_we = (state == S_DATA && rx_valid && op == OP_EEWR)
               || (state == S_EXEC && op == OP_REBOOT && img_decr);
   assign ee_wa = (state == S_DATA) ? addr[7:0] : FW_VER_ADDR;
   assign ee_wd = (state == S_DATA) ? rx_byte : NEW_FW_VER;
   always_ff @(posedge hclk) begin
      if (clk_en && ee_we) begin
         ee[ee_wa] <= ee_wd;
      end
      if (clk_en && state == S_DATA && rx_valid && op == OP_FLWR && res == RES_OK) begin
         img[addr[13:0]] <= rx_byte;
      end
   end

   assign next_len = {arg[2], rx_byte};

   // command sequencer and settings
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state <= S_HDR;
         op <= 8'h00; res <= RES_OK; last <= 8'h00; dcnt <= 8'h00;
         scnt <= 8'h00; saddr <= 8'h00; addr <= 16'h0; flen <= 16'h0;
         acnt <= 3'h0; ridx <= 3'h0; rlen <= 3'h0; tmr <= 32'h0;
         arg <= '{default: 8'h00};
         resp <= '{default: 8'h00};
         gpo <= GPO_RST; ratio <= PWM_RST; power <= PWR_RST;
         vid <= 16'h0; vid_set <= 1'b0;
         img_written <= 1'b0; img_decr <= 1'b0; reboot <= 1'b0;
      end else if (clk_en) begin
         reboot <= 1'b0;
         tmr <= rx_valid ? 32'h0 : tmr + 32'h1;
         case (state)
            S_HDR: if (rx_valid && rx_byte == HDR && !tx_busy) state <= S_OP;
            S_OP: if (rx_valid) begin
               acnt <= 3'h0;
               op   <= rx_byte;
               if (!known_op(rx_byte)) state <= S_HDR;
               else if (arg_cnt(rx_byte) == 3'h0) state <= S_EXEC;
               else state <= S_ARG;
            end
            S_ARG: if (rx_valid) begin
               arg[acnt[1:0]] <= rx_byte;
               acnt <= acnt + 3'h1;
               if (acnt == arg_cnt(op) - 3'h1) begin
                  state <= S_EXEC;
                  if (op == OP_EEWR) begin
                     addr <= {8'h00, arg[0]};
                     dcnt <= rx_byte;
                     tmr  <= 32'h0;
                     state <= (rx_byte == 8'h00) ? S_WAIT : S_DATA;
                  end
                  if (op == OP_FLWR) begin
                     addr <= {arg[0], arg[1]};
                     flen <= next_len;
                     dcnt <= rx_byte;
                     if (img_decr) res <= RES_VALID;
                     else if (next_len == 16'h0 || next_len > FL_LEN_MAX
                        || {1'b0, arg[0], arg[1]} + {1'b0, next_len} > IMG_SIZE)
                        res <= RES_BOUND;
                     else res <= RES_OK;
                     if (rx_byte != 8'h00) state <= S_DATA;
                  end
               end
            end else if (tmr == 32'(TMO_CYC - 1)) state <= S_HDR;
            S_DATA: if (rx_valid) begin
               last <= rx_byte;
               addr <= addr + 16'h1;
               dcnt <= dcnt - 8'h1;
               if (op == OP_FLWR && res == RES_OK) img_written <= 1'b1;
               if (dcnt == 8'h1) state <= (op == OP_EEWR) ? S_WAIT : S_EXEC;
            end else if (tmr == 32'(TMO_CYC - 1)) begin
               if (op == OP_FLWR) begin
                  res <= RES_TMO;
                  state <= S_EXEC;
               end else state <= S_HDR;
            end
            S_WAIT: if (tmr == 32'(EE_WRITE_CYC - 1)) state <= S_EXEC;
            S_EXEC: begin
               ridx  <= 3'h0;
               scnt  <= 8'h00;
               state <= S_RESP;
               resp[0] <= HDR;
               resp[1] <= op;
               rlen  <= 3'h2;
               case (op)
                  OP_GPO: begin
                     gpo <= arg[0][1:0];
                     resp[1] <= {6'h0, arg[0][1:0]};
                  end
                  OP_PWM: ratio <= arg[0];
                  OP_PWR: begin
                     if (arg[0] <= PWR_MAX) power <= arg[0][1:0];
                     resp[1] <= (arg[0] <= PWR_MAX) ? arg[0] : {6'h0, power};
                  end
                  OP_EERD: begin
                     resp[1] <= arg[0]; resp[2] <= arg[1]; rlen <= 3'h3;
                     saddr <= arg[0]; scnt <= arg[1];
                  end
                  OP_EEWR: begin
                     resp[0] <= arg[0]; resp[1] <= arg[1]; resp[2] <= last;
                     rlen <= 3'h3;
                  end
                  OP_VID: begin
                     if (arg[0] != VID_SUB) state <= S_HDR;
                     if ({arg[1], arg[2]} == VID_QUERY) begin
                        resp[0] <= vid_set ? VID_ON : VID_OFF;
                        resp[1] <= vid_set ? VID_ON : VID_OFF;
                     end else begin
                        resp[0] <= VID_ON;
                        resp[1] <= VID_ON;
                        if (!vid_set && arg[0] == VID_SUB) begin
                           vid <= {arg[1], arg[2]};
                           vid_set <= 1'b1;
                        end
                     end
                  end
                  OP_FLWR: begin
                     resp[2] <= res; resp[3] <= arg[0]; resp[4] <= arg[1];
                     rlen <= 3'h5;
                  end
                  OP_DECR: begin
                     rlen <= 3'h3;
                     if (img_decr) resp[2] <= RES_VALID;
                     else if (!img_written) resp[2] <= RES_INTEG;
                     else begin
                        resp[2] <= RES_OK;
                        img_decr <= 1'b1;
                     end
                  end
                  OP_ERASE: begin
                     img_written <= 1'b0;
                     img_decr <= 1'b0;
                  end
                  OP_REBOOT: begin
                     reboot <= 1'b1;
                     state <= S_HDR;
                     gpo <= GPO_RST; ratio <= PWM_RST; power <= PWR_RST;
                     if (img_decr) begin
                        img_decr <= 1'b0;
                        img_written <= 1'b0;
                     end
                  end
                  default: state <= S_HDR;
               endcase
            end
            S_RESP: if (tx_go) begin
               ridx <= ridx + 3'h1;
               if (ridx == rlen - 3'h1) state <= (scnt != 8'h00) ? S_STREAM : S_HDR;
            end
            S_STREAM: if (tx_go) begin
               saddr <= saddr + 8'h1;
               scnt  <= scnt - 8'h1;
               if (scnt == 8'h1) state <= S_HDR;
            end
            default: state <= S_HDR;
         endcase
      end
   end

   // pwm generator and output drivers
   assign hi_cyc = ({16'h0, ratio} * 24'(PWM_CYC)) >> 8;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pc <= 16'h0; pwm_out <= 1'b0; gpo_out <= GPO_RST;
         peer_accept <= 1'b1; max_power <= PWR_RST;
      end else if (clk_en) begin
         pc <= (pc == 16'(PWM_CYC - 1)) ? 16'h0 : pc + 16'h1;
         pwm_out <= (ratio == PWM_FULL) || ({8'h0, pc} < hi_cyc);
         gpo_out <= hop_override_en ? hop_override_val : gpo;
         peer_accept <= !vid_set || peer_vid == vid;
         max_power <= power;
      end
   end

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn || !clk_en);
   sequence s_gpo_cmd;
      state == S_EXEC && op == OP_GPO ##1 !hop_override_en [*2];
   endsequence
   property p_gpo; s_gpo_cmd |-> gpo_out == $past(arg[0][1:0], 2); endproperty
   a_gpo: assert property (p_gpo) else $error("gpo level wrong");
   property p_pwm_lo; ratio == 8'h00 && $past(ratio) == 8'h00 |-> !pwm_out; endproperty
   a_pwm_lo: assert property (p_pwm_lo) else $error("pwm not low");
   property p_pwm_hi; ratio == PWM_FULL && $past(ratio) == PWM_FULL |-> pwm_out; endproperty
   a_pwm_hi: assert property (p_pwm_hi) else $error("pwm not high");
   property p_pwr; state == S_EXEC && op == OP_PWR && arg[0] > PWR_MAX |=> $stable(power);
   endproperty
   a_pwr: assert property (p_pwr) else $error("bad power code taken");
   property p_eewr; state == S_EXEC && op == OP_EEWR |-> $past(state) == S_WAIT; endproperty
   a_eewr: assert property (p_eewr) else $error("eeprom answer early");
   property p_vid; vid_set |=> vid_set && $stable(vid); endproperty
   a_vid: assert property (p_vid) else $error("vendor code changed");
   sequence s_vid_query;
      state == S_EXEC && op == OP_VID && arg[0] == VID_SUB && {arg[1], arg[2]} == VID_QUERY;
   endsequence
   property p_vid_query; s_vid_query |=> resp[0] == ($past(vid_set) ? VID_ON : VID_OFF)
      && $stable(vid); endproperty
   a_vid_query: assert property (p_vid_query) else $error("vendor query wrong");
   property p_peer; vid_set && $past(vid_set) && peer_vid != vid && $stable(peer_vid)
      |-> !peer_accept; endproperty
   a_peer: assert property (p_peer) else $error("foreign peer accepted");
   property p_bound; state == S_EXEC && op == OP_FLWR && res != RES_TMO && !img_decr
      && {1'b0, addr} > IMG_SIZE |-> res == RES_BOUND; endproperty
   a_bound: assert property (p_bound) else $error("bounds not flagged");
   property p_decr; state == S_EXEC && op == OP_DECR && img_decr |=> resp[2] == RES_VALID;
   endproperty
   a_decr: assert property (p_decr) else $error("decrypt status wrong");
   property p_unknown; state == S_OP && rx_valid && !known_op(rx_byte) |=> state == S_HDR
      ##1 state == S_HDR; endproperty
   a_unknown: assert property (p_unknown) else $error("unknown opcode kept");
   property p_one; state == S_HDR && tx_busy |=> state == S_HDR; endproperty
   a_one: assert property (p_one) else $error("header taken while sending");
endmodule // cfc_cmd

// ===== cfc_pkg.sv
// constants, types and codes of the framed command interpreter
// assumes a single 25 MHz clock domain
package cfc_pkg;
   localparam logic [7:0]  HDR         = 8'hcc;
   localparam logic [7:0]  OP_GPO      = 8'h23;
   localparam logic [7:0]  OP_PWM      = 8'h24;
   localparam logic [7:0]  OP_PWR      = 8'h25;
   localparam logic [7:0]  OP_EERD     = 8'hc0;
   localparam logic [7:0]  OP_EEWR     = 8'hc1;
   localparam logic [7:0]  OP_FLWR     = 8'hc4;
   localparam logic [7:0]  OP_DECR     = 8'hc5;
   localparam logic [7:0]  OP_ERASE    = 8'hc6;
   localparam logic [7:0]  OP_VID      = 8'hf2;
   localparam logic [7:0]  OP_REBOOT   = 8'hff;
   localparam logic [7:0]  VID_SUB     = 8'h06;
   localparam logic [15:0] VID_QUERY   = 16'hffff;
   localparam logic [7:0]  VID_ON      = 8'h00;
   localparam logic [7:0]  VID_OFF     = 8'hff;
   localparam logic [7:0]  RES_OK      = 8'h00;
   localparam logic [7:0]  RES_INTEG   = 8'h01;
   localparam logic [7:0]  RES_NOMEM   = 8'h02;
   localparam logic [7:0]  RES_TMO     = 8'h03;
   localparam logic [7:0]  RES_VALID   = 8'h04;
   localparam logic [7:0]  RES_BOUND   = 8'h06;
   localparam logic [7:0]  PWR_MAX     = 8'h03;
   localparam logic [7:0]  PWM_FULL    = 8'hff;
   localparam logic [16:0] IMG_SIZE    = 17'h03c00;
   localparam logic [15:0] FL_LEN_MAX  = 16'h00ff;
   localparam int          EE_DEPTH    = 256;
   localparam logic [7:0]  FW_VER_ADDR = 8'h00;
   localparam int          CLK_PERIOD_NS = 40;
   localparam int          CLK_HZ      = 25_000_000;
   localparam int          BAUD_RATE   = 115200;
   localparam logic [15:0] BAUD_DIV    = 16'(CLK_HZ / BAUD_RATE);
   localparam int          PWM_PERIOD_NS = 630_100;
   localparam int          PWM_PERIOD_CYC = PWM_PERIOD_NS / CLK_PERIOD_NS;
   localparam int          EE_WRITE_NS = 5_000;
   localparam int          EE_WRITE_CYC = (EE_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          RX_TIMEOUT_MS = 100;
   localparam int          RX_TIMEOUT_CYC = RX_TIMEOUT_MS * (CLK_HZ / 1000);
   localparam logic [7:0]  REG_CTRL    = 8'h00;
   localparam logic [7:0]  REG_BAUD    = 8'h04;
   localparam logic [7:0]  REG_STAT    = 8'h08;
   localparam logic [7:0]  REG_PWM     = 8'h0c;
   localparam logic        FLOW_RST    = 1'b1;
   localparam logic [1:0]  GPO_RST     = 2'h0;
   localparam logic [7:0]  PWM_RST     = 8'h00;
   localparam logic [1:0]  PWR_RST     = 2'h0;
   typedef struct packed {
      logic        flow_en;
      logic [15:0] baud_div;
   } cfc_ctrl_t;
   typedef struct packed {
      logic       busy;
      logic       img_decr;
      logic       img_written;
      logic       vid_set;
      logic [1:0] max_power;
      logic [1:0] gpo;
   } cfc_stat_t;
   typedef enum logic [2:0] {S_HDR, S_OP, S_ARG, S_DATA, S_WAIT, S_EXEC, S_RESP, S_STREAM}
      cfc_state_t;
endpackage

// ===== cfc_host.sv
// serial host model: frames command bytes and collects reply bytes
// assumes DIV equals the baud divider the bench programs over the bus
`timescale 1ns/1ps
module cfc_host #(
   parameter int DIV = 16
) (
   input  wire logic hclk,
   output logic      uart_rxd,
   input  wire logic uart_txd,
   output logic      uart_cts_n,
   input  wire logic uart_rts_n
);
   logic [7:0] rxq[$];
   initial begin
      uart_rxd = 1'b1;
      uart_cts_n = 1'b0;
   end
   // one 8n1 frame, lsb first, held off while the device is not ready
   task automatic send(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      while (uart_rts_n !== 1'b0) @(posedge hclk);
      for (int i = 0; i < 10; i++) begin
         uart_rxd <= f[i];
         repeat (DIV) @(posedge hclk);
      end
   endtask
   // reply bytes sampled mid-bit
   initial begin : rx_proc
      logic [7:0] b;
      forever begin
         @(negedge uart_txd);
         repeat (DIV / 2) @(posedge hclk);
         for (int i = 0; i < 8; i++) begin
            repeat (DIV) @(posedge hclk);
            b[i] = uart_txd;
         end
         repeat (DIV) @(posedge hclk);
         rxq.push_back(b);
      end
   end
endmodule // cfc_host

// ===== cfc_tb.sv
// self-checking bench for the framed command interpreter
// assumes the host model runs at the bit time written to the baud register
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin failures++; \
   $display("[FAIL] %0t got %0h want %0h", $time, a, b); end end
module tb;
   import cfc_pkg::*;
   typedef logic [7:0] cfc_bytes_t [];
   logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hop_en = 0, clk_en = 1;
   logic [2:0]  hsize = 0;
   logic        txd, rxd, cts_n, rts_n, hreadyout, hresp, pwm_out, peer_accept, reboot;
   logic [1:0]  htrans = 0, hop_val = 0, gpo_out, max_power;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
   logic [15:0] peer_vid = 0;
   logic [7:0]  got;
   int          failures = 0, total_checks = 0, reboots = 0;
   always #20 hclk = ~hclk;
   always @(posedge hclk) if (reboot === 1'b1) reboots++;
   cfc_cmd #(.PWM_CYC(64), .TMO_CYC(2000), .NEW_FW_VER(8'h01)) dut_u (.hclk(hclk),
      .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .uart_rxd(rxd), .uart_txd(txd),
      .uart_cts_n(cts_n), .uart_rts_n(rts_n), .hop_override_en(hop_en),
      .hop_override_val(hop_val), .gpo_out(gpo_out), .pwm_out(pwm_out),
      .max_power(max_power), .peer_vid(peer_vid), .peer_accept(peer_accept), .reboot(reboot));
   cfc_host #(.DIV(16)) host_u (.hclk(hclk), .uart_rxd(rxd), .uart_txd(txd),
      .uart_cts_n(cts_n), .uart_rts_n(rts_n));
   task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
      hsel <= 1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      hsize <= 3'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel <= 0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task run(input cfc_bytes_t tx, input cfc_bytes_t ex);
      int n;
      foreach (tx[i]) host_u.send(tx[i]);
      foreach (ex[i]) begin
         n = 0;
         while (host_u.rxq.size() == 0 && n < 4000) begin @(posedge hclk); n++; end
         got = (host_u.rxq.size() > 0) ? host_u.rxq.pop_front() : 8'hxx;
         `CHK(got, ex[i])
      end
   endtask
   task t_io;
      int hi;
      cfc_bytes_t pr;
      int pe[3];
      pr = '{8'h00, 8'h80, PWM_FULL};
      pe = '{0, 32, 64};
      run('{HDR, OP_GPO, 8'h02}, '{HDR, 8'h02});
      clk_en <= 0;
      hop_en <= 1;
      hop_val <= 2'h1;
      repeat (3) @(posedge hclk);
      `CHK(gpo_out, 2'h2)
      clk_en <= 1;
      repeat (3) @(posedge hclk);
      `CHK(gpo_out, 2'h1)
      hop_en <= 0;
      repeat (3) @(posedge hclk);
      `CHK(gpo_out, 2'h2)
      host_u.uart_cts_n <= 1'b1;
      fork
         run('{HDR, OP_GPO, 8'h01}, '{HDR, 8'h01});
         begin
            repeat (900) @(posedge hclk);
            `CHK(host_u.rxq.size(), 0)
            host_u.uart_cts_n <= 1'b0;
         end
      join
      `CHK(gpo_out, 2'h1)
      foreach (pr[k]) begin
         run('{HDR, OP_PWM, pr[k]}, '{HDR, OP_PWM});
         repeat (70) @(posedge hclk);
         hi = 0;
         repeat (64) begin @(posedge hclk); hi += int'(pwm_out === 1'b1); end
         `CHK(hi, pe[k])
      end
      run('{HDR, OP_PWR, 8'h03}, '{HDR, 8'h03});
      run('{HDR, OP_PWR, 8'h05}, '{HDR, 8'h03});
      host_u.send(HDR);
      host_u.send(8'h77);
      repeat (400) @(posedge hclk);
      `CHK(host_u.rxq.size(), 0)
      `CHK(max_power, 2'h3)
      $display("done io");
   endtask
   task t_vid;
      run('{HDR, OP_EEWR, 8'h10, 8'h02, 8'haa, 8'hbb}, '{8'h10, 8'h02, 8'hbb});
      run('{HDR, OP_EERD, 8'h10, 8'h02}, '{HDR, 8'h10, 8'h02, 8'haa, 8'hbb});
      run('{HDR, OP_VID, VID_SUB, 8'hff, 8'hff}, '{VID_OFF, VID_OFF});
      run('{HDR, OP_VID, VID_SUB, 8'h12, 8'h34}, '{VID_ON, VID_ON});
      run('{HDR, OP_VID, VID_SUB, 8'h56, 8'h78}, '{VID_ON, VID_ON});
      run('{HDR, OP_VID, VID_SUB, 8'hff, 8'hff}, '{VID_ON, VID_ON});
      peer_vid <= 16'h1234;
      repeat (3) @(posedge hclk);
      `CHK(peer_accept, 1'b1)
      peer_vid <= 16'h5678;
      repeat (3) @(posedge hclk);
      `CHK(peer_accept, 1'b0)
      $display("done eeprom and vendor");
   endtask
   task t_flash;
      run('{HDR, OP_DECR}, '{HDR, OP_DECR, RES_INTEG});
      run('{HDR, OP_FLWR, 8'h3b, 8'hff, 8'h00, 8'h02, 8'h11, 8'h22},
          '{HDR, OP_FLWR, RES_BOUND, 8'h3b, 8'hff});
      run('{HDR, OP_FLWR, 8'h00, 8'h00, 8'h00, 8'h01, 8'h55},
          '{HDR, OP_FLWR, RES_OK, 8'h00, 8'h00});
      run('{HDR, OP_DECR}, '{HDR, OP_DECR, RES_OK});
      run('{HDR, OP_DECR}, '{HDR, OP_DECR, RES_VALID});
      run('{HDR, OP_FLWR, 8'h00, 8'h01, 8'h00, 8'h01, 8'h66},
          '{HDR, OP_FLWR, RES_VALID, 8'h00, 8'h01});
      host_u.send(HDR);
      host_u.send(OP_REBOOT);
      repeat (20) @(posedge hclk);
      `CHK(reboots, 1)
      `CHK(max_power, 2'h0)
      run('{HDR, OP_EERD, FW_VER_ADDR, 8'h01}, '{HDR, FW_VER_ADDR, 8'h01, 8'h01});
      run('{HDR, OP_EERD, 8'h10, 8'h02}, '{HDR, 8'h10, 8'h02, 8'haa, 8'hbb});
      run('{HDR, OP_ERASE}, '{HDR, OP_ERASE});
      $display("done flash");
   endtask
   task summarize;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge hclk);
      hresetn <= 1;
      @(posedge hclk);
      ahb(0, 32'h0, 32'h0);
      `CHK(rd, 32'h1)
      `CHK(hresp, 1'b0)
      ahb(1, 32'h0, 32'h0);
      ahb(0, 32'h0, 32'h0);
      `CHK(rd, 32'h0)
      ahb(1, 32'h0, 32'h1);
      ahb(0, 32'h4, 32'h0);
      `CHK(rd, 32'(BAUD_DIV))
      ahb(1, 32'h4, 32'h10);
      ahb(0, 32'h40, 32'h0);
      `CHK(rd, 32'h0)
      $display("done registers");
      t_io;
      t_vid;
      t_flash;
      summarize;
   end
   initial begin
      #4_000_000;
      failures++;
      summarize;
   end
endmodule // tb
